// file: include/amw_pkg.sv
// Purpose: shared constants and types for the multiple-sector write block
// Assumes: 16-bit data words, 256 words per sector or log page
// Notes: opcodes, field positions and bit positions of the answer fields
package amw_pkg;
   // opcodes handled by this block
   localparam logic [7:0] OP_LOG_PIO = 8'h3F;
   localparam logic [7:0] OP_LOG_DMA = 8'h57;
   localparam logic [7:0] OP_MULT28 = 8'hC5;
   localparam logic [7:0] OP_MULT48 = 8'h39;
   localparam logic [7:0] OP_MULT_FUA = 8'hCE;
   // words per sector, minus one, for the word counter
   localparam logic [7:0] SECTOR_LAST_WORD = 8'hFF;
   // log command field positions inside the lba
   localparam int LOG_ADDR_LO = 0;
   localparam int PAGE_LO_LO = 8;
   localparam int PAGE_HI_LO = 32;
   localparam int RSVD_A_LO = 16;
   localparam int RSVD_A_HI = 31;
   localparam int RSVD_B_LO = 40;
   localparam int RSVD_B_HI = 47;
   // error field bits
   localparam int ERR_ICRC = 7;
   localparam int ERR_IDNF = 4;
   localparam int ERR_ABRT = 2;
   // status field bits
   localparam int STS_DF = 5;
   localparam int STS_SENSE = 1;
   localparam int STS_ERR = 0;
   localparam logic [7:0] ERR_RESET = 8'h00;
   localparam logic [7:0] STS_RESET = 8'h00;
   typedef enum logic [2:0] {
      AMW_IDLE = 3'b000,
      AMW_CHECK = 3'b001,
      AMW_XFER = 3'b010,
      AMW_DRAIN = 3'b011,
      AMW_COMMIT = 3'b100,
      AMW_DONE = 3'b101
   } amw_state_t;
endpackage

// file: hdl/amw_buf2.sv
// Purpose: two-entry buffer between the data port and the media side
// Assumes: both sides on clk
// Notes: full after two words held, so a media stall reaches the host
`timescale 1ns/1ps
module amw_buf2 #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   logic [WIDTH-1:0] mem [2];
   logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [1:0] count, next_count;
   logic push, pop;

   // handshakes straight from occupancy
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // pointer and occupancy update
   always_comb begin
      next_wr_ptr = push ? ~wr_ptr : wr_ptr;
      next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
      next_count = count;
      if (push & ~pop) begin
         next_count = count + 2'h1;
      end else if (pop & ~push) begin
         next_count = count - 2'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         mem[0] <= '0;
         mem[1] <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         if (push) begin
            mem[wr_ptr] <= in_data;
         end
      end
   end
endmodule

// file: hdl/amw_decode.sv
// Purpose: opcode recognition and count expansion
// Assumes: fields held stable by the caller
// Notes: purely combinational
`timescale 1ns/1ps
module amw_decode (
   input wire logic [7:0] opcode,
   input wire logic [15:0] count,
   output logic known,
   output logic is_log,
   output logic is_dma,
   output logic is_multi,
   output logic is_fua,
   output logic [16:0] count_exp
);
   // classify the opcode and widen the count
   always_comb begin
      known = 1'b1;
      is_log = 1'b0;
      is_dma = 1'b0;
      is_multi = 1'b0;
      is_fua = 1'b0;
      count_exp = {1'b0, count};
      case (opcode)
         amw_pkg::OP_LOG_PIO: is_log = 1'b1;
         amw_pkg::OP_LOG_DMA: begin
            is_log = 1'b1;
            is_dma = 1'b1;
         end
         amw_pkg::OP_MULT28: begin
            is_multi = 1'b1;
            // zero means 256 sectors
            count_exp = (count[7:0] == 8'h00) ? 17'h00100
               : {9'h000, count[7:0]};
         end
         amw_pkg::OP_MULT48, amw_pkg::OP_MULT_FUA: begin
            is_multi = 1'b1;
            is_fua = (opcode == amw_pkg::OP_MULT_FUA);
            // zero means 65536 sectors
            count_exp = (count == 16'h0000) ? 17'h10000
               : {1'b0, count};
         end
         default: known = 1'b0;
      endcase
   end
endmodule

// file: hdl/amw_write_ctrl.sv
// Purpose: decode and run the log and multiple-sector write commands
// Assumes: all inputs come from logic on clk; one command at a time
// Notes: error and status fields are held until the next command
`timescale 1ns/1ps
module amw_write_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   input wire logic [15:0] cmd_feature,
   input wire logic [15:0] cmd_count,
   input wire logic [47:0] cmd_lba,
   input wire logic [7:0] multiple_size,
   input wire logic write_cache_en,
   output logic [7:0] log_sel,
   input wire logic [15:0] log_size,
   input wire logic log_supported,
   input wire logic log_read_only,
   input wire logic log_avail,
   input wire logic data_valid,
   input wire logic [15:0] data_in,
   output logic data_ready,
   output logic media_valid,
   output logic [15:0] media_data,
   input wire logic media_ready,
   input wire logic media_err,
   input wire logic [47:0] media_err_lba,
   input wire logic crc_err,
   input wire logic device_fault,
   input wire logic sense_avail,
   output logic commit_req,
   input wire logic commit_done,
   output logic busy,
   output logic data_req,
   output logic irq,
   output logic [7:0] command_error_flags,
   output logic [7:0] command_completion_status,
   output logic [47:0] lba_out
);
   amw_pkg::amw_state_t state, next_state;
   logic [7:0] opcode, next_opcode;
   logic [15:0] feature, next_feature;
   logic [15:0] count, next_count;
   logic [47:0] lba, next_lba;
   logic [16:0] sectors_left, next_sectors_left;
   logic [7:0] word_idx, next_word_idx;
   logic [7:0] blk_size, next_blk_size;
   logic [7:0] blk_left, next_blk_left;
   logic [7:0] err, next_err;
   logic dfault, next_dfault;
   logic sense, next_sense;
   logic lba_held, next_lba_held;
   logic [47:0] next_lba_out;
   logic [7:0] next_error_flags, next_status;
   logic next_irq;
   logic known, is_log, is_dma, is_multi, is_fua;
   logic [16:0] count_exp;
   logic [15:0] page_num;
   logic [16:0] page_end;
   logic log_bad, abort;
   logic buf_in_ready, take;
   logic err_any;

   amw_decode u_decode (
      .opcode(opcode),
      .count(count),
      .known(known),
      .is_log(is_log),
      .is_dma(is_dma),
      .is_multi(is_multi),
      .is_fua(is_fua),
      .count_exp(count_exp)
   );

   // stalls on the media side back up into data_ready
   amw_buf2 #(
      .WIDTH(16)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(take),
      .in_data(data_in),
      .in_ready(buf_in_ready),
      .out_valid(media_valid),
      .out_data(media_data),
      .out_ready(media_ready)
   );

   // log field extraction; page number split across two lba bytes
   assign log_sel = lba[amw_pkg::LOG_ADDR_LO +: 8];
   assign page_num = {lba[amw_pkg::PAGE_HI_LO +: 8],
      lba[amw_pkg::PAGE_LO_LO +: 8]};
   assign page_end = {1'b0, page_num} + {1'b0, count};

   // log checks are shared by both log opcodes
   assign log_bad = (count == 16'h0000)
      | ({1'b0, count} > {1'b0, log_size})
      | (page_end > {1'b0, log_size})
      | log_read_only
      | ~log_supported
      | (feature != 16'h0000)
      | (lba[amw_pkg::RSVD_A_HI:amw_pkg::RSVD_A_LO] != 16'h0000)
      | (lba[amw_pkg::RSVD_B_HI:amw_pkg::RSVD_B_LO] != 8'h00);
   // set multiple of zero means no block size, so refuse
   assign abort = ~known | (is_log & log_bad)
      | (is_multi & (multiple_size == 8'h00));

   // host may only push words while transferring and error free
   assign err_any = (err != 8'h00) | dfault;
   assign data_ready = (state == amw_pkg::AMW_XFER) & buf_in_ready
      & ~err_any;
   assign take = data_valid & data_ready;
   assign data_req = (state == amw_pkg::AMW_XFER);
   assign busy = (state != amw_pkg::AMW_IDLE);
   assign commit_req = (state == amw_pkg::AMW_COMMIT);

   // command sequencing, counters and error capture
   always_comb begin
      next_state = state;
      next_opcode = opcode;
      next_feature = feature;
      next_count = count;
      next_lba = lba;
      next_sectors_left = sectors_left;
      next_word_idx = word_idx;
      next_blk_size = blk_size;
      next_blk_left = blk_left;
      next_err = err;
      next_dfault = dfault;
      next_sense = sense;
      next_lba_held = lba_held;
      next_lba_out = lba_out;
      next_error_flags = command_error_flags;
      next_status = command_completion_status;
      next_irq = 1'b0;
      case (state)
         amw_pkg::AMW_IDLE: begin
            if (cmd_valid) begin
               next_opcode = cmd_opcode;
               next_feature = cmd_feature;
               next_count = cmd_count;
               next_lba = cmd_lba;
               next_err = 8'h00;
               next_dfault = 1'b0;
               next_sense = 1'b0;
               next_lba_held = 1'b0;
               next_state = amw_pkg::AMW_CHECK;
            end
         end
         amw_pkg::AMW_CHECK: begin
            next_word_idx = 8'h00;
            next_sectors_left = count_exp;
            if (abort) begin
               next_err[amw_pkg::ERR_ABRT] = 1'b1;
               next_state = amw_pkg::AMW_DONE;
            end else if (is_log & ~log_avail) begin
               next_err[amw_pkg::ERR_IDNF] = 1'b1;
               next_state = amw_pkg::AMW_DONE;
            end else begin
               // pio log: a block per page; dma log: none until the end
               if (is_multi) begin
                  next_blk_size = multiple_size;
               end else begin
                  next_blk_size = is_dma ? 8'h00 : 8'h01;
               end
               next_blk_left = next_blk_size;
               next_state = amw_pkg::AMW_XFER;
            end
         end
         amw_pkg::AMW_XFER: begin
            if (take) begin
               next_word_idx = word_idx + 8'h01;
               if (word_idx == amw_pkg::SECTOR_LAST_WORD) begin
                  next_sectors_left = sectors_left - 17'h00001;
                  next_blk_left = blk_left - 8'h01;
                  if (sectors_left == 17'h00001) begin
                     // last block, full or short, ends in DONE's pulse
                     next_state = amw_pkg::AMW_DRAIN;
                  end else if (blk_left == 8'h01 && blk_size != 8'h00) begin
                     next_irq = 1'b1;
                     next_blk_left = blk_size;
                  end
               end
            end
            if (err_any) begin
               next_state = amw_pkg::AMW_DRAIN;
            end
         end
         amw_pkg::AMW_DRAIN: begin
            // wait for buffered words to reach the media first
            if (~media_valid) begin
               if (~err_any & (is_fua | ~write_cache_en)) begin
                  next_state = amw_pkg::AMW_COMMIT;
               end else begin
                  next_state = amw_pkg::AMW_DONE;
               end
            end
         end
         amw_pkg::AMW_COMMIT: begin
            if (commit_done | err_any) begin
               next_state = amw_pkg::AMW_DONE;
            end
         end
         amw_pkg::AMW_DONE: begin
            next_irq = 1'b1;
            next_error_flags = err;
            next_status = amw_pkg::STS_RESET;
            next_status[amw_pkg::STS_DF] = dfault;
            next_status[amw_pkg::STS_SENSE] = err_any & sense;
            next_status[amw_pkg::STS_ERR] = err_any;
            if (lba_held) begin
               next_lba_out = lba;
            end
            next_state = amw_pkg::AMW_IDLE;
         end
         default: next_state = amw_pkg::AMW_IDLE;
      endcase
      // events from the link and media while busy, except in DONE; not taken in IDLE, so a new command's clears always apply
      if (state != amw_pkg::AMW_IDLE && state != amw_pkg::AMW_DONE) begin
         if (crc_err) begin
            next_err[amw_pkg::ERR_ICRC] = 1'b1;
         end
         if (media_err) begin
            next_err[amw_pkg::ERR_ABRT] = 1'b1;
            if (~lba_held) begin
               // only the first failing sector is kept
               next_lba = media_err_lba;
               next_lba_held = 1'b1;
            end
         end
         if (device_fault) begin
            next_dfault = 1'b1;
         end
         if (sense_avail) begin
            next_sense = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= amw_pkg::AMW_IDLE;
         opcode <= 8'h00;
         feature <= 16'h0000;
         count <= 16'h0000;
         lba <= 48'h000000000000;
         sectors_left <= 17'h00000;
         word_idx <= 8'h00;
         blk_size <= 8'h00;
         blk_left <= 8'h00;
         err <= 8'h00;
         dfault <= 1'b0;
         sense <= 1'b0;
         lba_held <= 1'b0;
         lba_out <= 48'h000000000000;
         command_error_flags <= amw_pkg::ERR_RESET;
         command_completion_status <= amw_pkg::STS_RESET;
         irq <= 1'b0;
      end else begin
         state <= next_state;
         opcode <= next_opcode;
         feature <= next_feature;
         count <= next_count;
         lba <= next_lba;
         sectors_left <= next_sectors_left;
         word_idx <= next_word_idx;
         blk_size <= next_blk_size;
         blk_left <= next_blk_left;
         err <= next_err;
         dfault <= next_dfault;
         sense <= next_sense;
         lba_held <= next_lba_held;
         lba_out <= next_lba_out;
         command_error_flags <= next_error_flags;
         command_completion_status <= next_status;
         irq <= next_irq;
      end
   end
endmodule

// file: bench/amw_write_ctrl_asserts.sv
// Purpose: port-level checks on the write command block
// Assumes: one clock, async high reset
// Notes: bound onto every controller instance
`timescale 1ns/1ps
module amw_write_ctrl_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic busy,
   input wire logic irq,
   input wire logic data_valid,
   input wire logic data_ready,
   input wire logic data_req,
   input wire logic media_valid,
   input wire logic commit_req,
   input wire logic [7:0] command_error_flags,
   input wire logic [7:0] command_completion_status,
   input wire logic [47:0] lba_out
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   // command taken, then two busy cycles at least
   sequence s_take;
      cmd_valid && !busy;
   endsequence
   sequence s_idle2;
      !busy ##1 !busy;
   endsequence
   a_take_busy: assert property (s_take |=> busy [*2])
      else $error("busy missing after a taken command");
   a_done_irq: assert property ($fell(busy) |-> irq)
      else $error("completion without interrupt");
   a_irq_single: assert property (irq |=> !irq)
      else $error("interrupt longer than one cycle");
   a_ready_xfer: assert property (data_ready |-> data_req)
      else $error("word taken outside transfer");
   a_word_media: assert property (data_valid && data_ready |=> media_valid)
      else $error("taken word not offered to media");
   a_err_status: assert property ($fell(busy) && command_error_flags != 8'h00
      |-> command_completion_status[0])
      else $error("error flags without error status");
   a_sense_err: assert property (command_completion_status[1]
      |-> command_completion_status[0])
      else $error("sense bit without error bit");
   a_lba_idle: assert property (s_idle2 |-> $stable(lba_out))
      else $error("failing address moved while idle");
   a_commit_end: assert property (commit_req |-> busy && !data_req)
      else $error("commit during transfer");
endmodule
bind amw_write_ctrl amw_write_ctrl_chk u_chk (
   .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .busy(busy), .irq(irq),
   .data_valid(data_valid), .data_ready(data_ready), .data_req(data_req),
   .media_valid(media_valid), .commit_req(commit_req),
   .command_error_flags(command_error_flags),
   .command_completion_status(command_completion_status),
   .lba_out(lba_out)
);

// file: bench/amw_media_model.sv
// Purpose: media side stand-in: stalls, fails a word, answers commits
// Assumes: err_at cleared between commands to restart the word count
// Notes: stalls one cycle in eight so the buffer really fills, yet the
// 256-sector run still fits the cycle budget
`timescale 1ns/1ps
module amw_media_model #(
   parameter logic [47:0] ERR_LBA = 48'h0000_0012_3456
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic media_valid,
   output logic media_ready,
   input wire logic commit_req,
   output logic commit_done,
   output logic media_err,
   output logic [47:0] media_err_lba,
   input wire logic [15:0] err_at
);
   logic [15:0] taken;
   logic [2:0] tick;
   assign media_err_lba = ERR_LBA;
   // slow media: late commit answer, periodic stall
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         taken <= 16'h0000;
         tick <= 3'h0;
         media_ready <= 1'b0;
         commit_done <= 1'b0;
         media_err <= 1'b0;
      end else begin
         tick <= tick + 3'h1;
         media_ready <= (tick != 3'h7);
         if (err_at == 16'h0000) taken <= 16'h0000;
         else if (media_valid && media_ready) taken <= taken + 16'h0001;
         media_err <= (err_at != 16'h0000) && (taken == err_at)
            && media_valid && media_ready;
         commit_done <= commit_req && (tick == 3'h7) && !commit_done;
      end
   end
endmodule

// file: bench/ata_multi_sector_write_decode_bench.sv
// Purpose: self-checking bench for the write command controller
// Assumes: host side driven here, media side by the model
// Notes: zero counts of 65536 sectors are too long to run here
`timescale 1ns/1ps
module ata_multi_sector_write_decode_bench;
   logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, write_cache_en = 1'b1;
   logic [7:0] cmd_opcode = 8'h00, multiple_size = 8'h01, log_sel;
   logic [15:0] cmd_feature = 16'h0000, cmd_count = 16'h0000;
   logic [47:0] cmd_lba = 48'h0, media_err_lba, lba_out;
   logic [15:0] log_size = 16'h0004, data_in = 16'h0000, media_data;
   logic [15:0] err_at = 16'h0000;
   logic log_supported = 1'b1, log_read_only = 1'b0, log_avail = 1'b1;
   logic data_valid = 1'b0, crc_err = 1'b0, device_fault = 1'b0;
   logic sense_avail = 1'b0, data_ready, media_valid, media_ready;
   logic media_err, commit_req, commit_done, busy, data_req, irq;
   logic [7:0] command_error_flags, command_completion_status;
   int num_errors = 0, comparisons = 0, words, irqs, commits, crc_at = 0;
   logic flt_on = 1'b0;
   always #5 clk = ~clk;
   amw_write_ctrl u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_opcode(cmd_opcode), .cmd_feature(cmd_feature),
      .cmd_count(cmd_count), .cmd_lba(cmd_lba),
      .multiple_size(multiple_size), .write_cache_en(write_cache_en),
      .log_sel(log_sel), .log_size(log_size), .log_supported(log_supported),
      .log_read_only(log_read_only), .log_avail(log_avail),
      .data_valid(data_valid), .data_in(data_in), .data_ready(data_ready),
      .media_valid(media_valid), .media_data(media_data),
      .media_ready(media_ready), .media_err(media_err),
      .media_err_lba(media_err_lba), .crc_err(crc_err),
      .device_fault(device_fault), .sense_avail(sense_avail),
      .commit_req(commit_req), .commit_done(commit_done), .busy(busy),
      .data_req(data_req), .irq(irq),
      .command_error_flags(command_error_flags),
      .command_completion_status(command_completion_status),
      .lba_out(lba_out));
   amw_media_model u_media (.clk(clk), .rst(rst), .media_valid(media_valid),
      .media_ready(media_ready), .commit_req(commit_req),
      .commit_done(commit_done), .media_err(media_err),
      .media_err_lba(media_err_lba), .err_at(err_at));
   task automatic report_and_stop;
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one command: host offers words while asked, until final interrupt
   task automatic run(input logic [7:0] op, input logic [15:0] cnt,
      input logic [47:0] lba, input logic [15:0] ft);
      int i;
      i = 0;
      words = 0;
      irqs = 0;
      commits = 0;
      cmd_opcode <= op;
      cmd_count <= cnt;
      cmd_lba <= lba;
      cmd_feature <= ft;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clk);
         i++;
         if (data_valid === 1'b1 && data_ready === 1'b1) words++;
         if (irq === 1'b1) irqs++;
         if (commit_req === 1'b1) commits++;
         // only while words are asked for, so no error outlives the run
         crc_err <= (crc_at != 0) && (words == crc_at) && data_req === 1'b1;
         // fault and sense follow the media failure, after it is latched
         device_fault <= flt_on && media_err === 1'b1;
         sense_avail <= flt_on && media_err === 1'b1;
         data_valid <= data_req;
         data_in <= words[15:0];
      end while (!(irq === 1'b1 && busy === 1'b0) && i < 80000);
      chk("finished", 48'h1, 48'(i < 80000));
      err_at <= 16'h0000;
   endtask
   // blocks of two over three sectors: short last block
   task automatic t_multi;
      multiple_size <= 8'h02;
      run(amw_pkg::OP_MULT28, 16'h0003, 48'h100, 16'h0);
      chk("words", 48'd768, 48'(words));
      chk("irqs", 48'd2, 48'(irqs));
      chk("status", 48'h0, 48'(command_completion_status));
      // low byte zero is 256 sectors; the high byte must be ignored
      multiple_size <= 8'hFF;
      run(amw_pkg::OP_MULT28, 16'hFF00, 48'h0, 16'h0);
      chk("words256", 48'd65536, 48'(words));
      chk("irqs256", 48'd2, 48'(irqs));
   endtask
   // forced media write and cache off commit; plain 48-bit does not
   // no device field reaches the block, so bit 6 stays the host's job
   task automatic t_commit;
      multiple_size <= 8'h01;
      run(amw_pkg::OP_MULT_FUA, 16'h0001, 48'h0, 16'h0);
      chk("fua_commit", 48'h1, 48'(commits > 0));
      run(amw_pkg::OP_MULT48, 16'h0001, 48'h0, 16'h0);
      chk("ext_nocommit", 48'h0, 48'(commits > 0));
      chk("ext_words", 48'd256, 48'(words));
      write_cache_en <= 1'b0;
      run(amw_pkg::OP_MULT28, 16'h0001, 48'h0, 16'h0);
      chk("nocache_commit", 48'h1, 48'(commits > 0));
      write_cache_en <= 1'b1;
   endtask
   // log writes: DMA once at end, PIO per page
   task automatic t_log;
      run(amw_pkg::OP_LOG_DMA, 16'h0001, 48'h0080, 16'h0);
      chk("dma_words", 48'd256, 48'(words));
      chk("dma_irqs", 48'd1, 48'(irqs));
      chk("log_sel", 48'h80, 48'(log_sel));
      run(amw_pkg::OP_LOG_PIO, 16'h0002, 48'h0280, 16'h0);
      chk("pio_words", 48'd512, 48'(words));
      chk("pio_irqs", 48'd2, 48'(irqs));
   endtask
   // every refusal except a nonzero upper reserved byte, for both log opcodes
   task automatic t_refuse;
      logic [15:0] c;
      logic [47:0] l;
      for (int k = 0; k < 16; k++) begin
         c = (k % 8 == 0) ? 16'h0 : (k % 8 == 1) ? 16'h5 : 16'h2;
         l = (k % 8 == 2) ? 48'h0380 : (k % 8 == 6) ? 48'h100080 : 48'h80;
         log_read_only <= (k % 8 == 3);
         log_supported <= (k % 8 != 4);
         log_avail <= (k % 8 != 7);
         run(k < 8 ? amw_pkg::OP_LOG_PIO : amw_pkg::OP_LOG_DMA, c, l,
            (k % 8 == 5) ? 16'h1 : 16'h0);
         chk("ref_err", (k % 8 == 7) ? 48'h10 : 48'h04,
            48'(command_error_flags));
         chk("ref_sts", 48'h01, 48'(command_completion_status));
         chk("ref_words", 48'h0, 48'(words));
      end
      log_read_only <= 1'b0;
      log_supported <= 1'b1;
      log_avail <= 1'b1;
      // unknown opcode, then a multiple write with no block size set
      run(8'h00, 16'h0001, 48'h0, 16'h0);
      chk("unk_err", 48'h04, 48'(command_error_flags));
      multiple_size <= 8'h00;
      run(amw_pkg::OP_MULT28, 16'h0001, 48'h0, 16'h0);
      chk("nomult_err", 48'h04, 48'(command_error_flags));
      chk("nomult_words", 48'h0, 48'(words));
      multiple_size <= 8'h01;
   endtask
   // media failure carrying fault and sense, then a crc failure
   // fault comes after the media error, else no word would ever move
   task automatic t_fail;
      @(posedge clk);
      err_at <= 16'd50;
      flt_on = 1'b1;
      run(amw_pkg::OP_MULT28, 16'h0002, 48'h0, 16'h0);
      flt_on = 1'b0;
      chk("lba_out", 48'h0000_0012_3456, lba_out);
      chk("err_media", 48'h04, 48'(command_error_flags));
      chk("sts_fault", 48'h23, 48'(command_completion_status));
      crc_at = 20;
      run(amw_pkg::OP_MULT28, 16'h0001, 48'h0, 16'h0);
      crc_at = 0;
      chk("err_crc", 48'h80, 48'(command_error_flags));
      chk("sts_crc", 48'h01, 48'(command_completion_status));
      chk("lba_kept", 48'h0000_0012_3456, lba_out);
   endtask
   // hang guard; the sequence needs about 79k cycles
   initial begin
      repeat (95000) @(posedge clk);
      num_errors++;
      report_and_stop;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_multi;
      t_commit;
      t_log;
      t_refuse;
      t_fail;
      report_and_stop;
   end
endmodule
